// ### sim/wcg_top_asserts.sv
// Port checker for the watchdog configuration guard.
// Assumes it is bound into wcg_top; one clock domain.
module wcg_top_asserts (
  // Clock, reset and bus
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Watchdog
  input wire logic safety_level_fuse_in,
  input wire logic wdt_kick_in,
  input wire logic wdt_reset_out,
  input wire logic [15:0] reset_vector_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  a_vec_zero: assert property (reset_vector_out == 16'h0000)
    else $error("reset vector not zero");
  a_pulse_one: assert property (wdt_reset_out |=> !wdt_reset_out)
    else $error("reset pulse too long");
  a_wait_first: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("no wait in first cycle");
  a_one_wait: assert property (avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("more than one wait cycle");
  a_idle_nowait: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("wait while idle");
  a_read_stable: assert property (!avs_read_in |=> $stable(avs_readdata_out))
    else $error("read data changed without read");
  // Fuse must have settled through its synchroniser first
  a_lvl2_enable: assert property (safety_level_fuse_in && $past(safety_level_fuse_in, 4)
    && avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h0
    |-> avs_readdata_out[3])
    else $error("enable not one at level two");
  a_kick_quiet: assert property (wdt_kick_in [*3] |=> !wdt_reset_out)
    else $error("reset pulse right after kick");
endmodule
bind wcg_top wcg_top_asserts i_wcg_top_asserts (.clk_sys_in, .resetn_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out,
  .safety_level_fuse_in, .wdt_kick_in, .wdt_reset_out, .reset_vector_out);

// ### sim/wcg_top_tb.sv
// Testbench for the watchdog configuration guard.
// Assumes the package, wcg_top and its checker are compiled first.
module wcg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] ctl = 4'h0, st = 4'h4, mk = 4'h8, vec = 4'hC;
  logic clk_sys_in = 1'b0, resetn_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic safety_level_fuse_in = 1'b0, wdt_osc_tick_in = 1'b0, wdt_kick_in = 1'b0;
  logic tick_en = 1'b0, w;
  logic [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'hF;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rdat;
  logic avs_waitrequest_out, wdt_reset_out, irq_out;
  logic [15:0] reset_vector_out;
  int n_mismatch = 0, total_checks = 0, cyc = 0, n;
  wcg_top i_wcg_top (.clk_sys_in, .resetn_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .safety_level_fuse_in, .wdt_osc_tick_in, .wdt_kick_in,
    .wdt_reset_out, .reset_vector_out, .irq_out);
  initial forever #2 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    if (tick_en) wdt_osc_tick_in <= !wdt_osc_tick_in;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report;
    end
  end
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Wait and data read at the rising edge, before that edge's updates land
  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do begin
      @(posedge clk_sys_in);
      w = avs_waitrequest_out;
      rdat = avs_readdata_out;
    end while (w !== 1'b0);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic ci(input logic exp);
    @(negedge clk_sys_in);
    chk(irq_out, exp);
    @(posedge clk_sys_in);
  endtask
  task automatic rst(input logic f);
    resetn_in <= 1'b0;
    safety_level_fuse_in <= f;
    repeat (16) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
  endtask
  initial begin
    rst(1'b0);
    rc(ctl, 32'h0);
    wr(mk, 32'h3);
    wr(ctl, 32'h8);
    rc(ctl, 32'h8);
    wr(ctl, 32'h0);
    rc(ctl, 32'h8);
    ci(1'b1);
    rc(st, 32'h2);
    ci(1'b0);
    wr(ctl, 32'h18);
    wr(ctl, 32'h21);
    rc(ctl, 32'h21);
    wr(ctl, 32'h18);
    repeat (3) @(posedge clk_sys_in);
    wr(ctl, 32'h21);
    rc(ctl, 32'h29);
    rc(st, 32'h2);
    wr(ctl, 32'h8);
    // Kick held across the start of ticking, then a full shortest timeout
    wdt_kick_in <= 1'b1;
    tick_en <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    wdt_kick_in <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (wdt_reset_out !== 1'b1 && n < 6000);
    chk(n > 4000 && n < 4400, 1'b1);
    @(posedge clk_sys_in);
    tick_en <= 1'b0;
    ci(1'b1);
    rc(st, 32'h1);
    rc(vec, 32'h0);
    rst(1'b1);
    rc(ctl, 32'h8);
    wr(ctl, 32'h1);
    rc(ctl, 32'h8);
    wr(ctl, 32'h18);
    wr(ctl, 32'h2);
    rc(ctl, 32'hA);
    final_report;
  end
endmodule

// ### verilog/wcg_pkg.sv
// Package for the watchdog configuration guard: register map, field layout, timing.
// Assumes a 250 MHz system clock and a 32-bit Avalon-MM register port.
package wcg_pkg;
  // Byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] MASK_OFS = 4'h8;
  localparam logic [3:0] VEC_OFS = 4'hC;
  // Control field positions
  localparam int TSEL_LO_POS = 0;
  localparam int WDE_POS = 3;
  localparam int CUB_POS = 4;
  localparam int TSEL_HI_POS = 5;
  // Status bits
  localparam int EV_TIMEOUT_POS = 0;
  localparam int EV_REFUSED_POS = 1;
  localparam int EV_COUNT = 2;
  // Reset values and largest timeout select code
  localparam logic [3:0] TSEL_RST = 4'h0;
  localparam logic [3:0] TSEL_MAX = 4'h9;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // Unlock window, in system clock cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // Shortest timeout in watchdog oscillator cycles
  localparam int BASE_TIMEOUT = 2048;

  typedef struct packed {
    logic watchdog_enable;
    logic [3:0] timeout_select;
  } wcg_cfg_type;
endpackage

// ### verilog/wcg_top.sv
// Watchdog configuration guard with timed unlock, timeout counter and reset request.
// Assumes software on Avalon-MM, a fuse level input and a watchdog oscillator tick from
// another domain; the fuse and tick are synchronised here.
//
// Our own choices: the register offsets and the Avalon-MM register port.
module wcg_top (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Fuse and watchdog oscillator
  input wire logic safety_level_fuse_in,
  input wire logic wdt_osc_tick_in,
  input wire logic wdt_kick_in,
  // Results
  output logic wdt_reset_out,
  output logic [15:0] reset_vector_out,
  output logic irq_out
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] fuse_sync_q;
  logic fuse_q;
  logic [2:0] tick_sync_q;
  logic tick_pulse;
  logic level2;
  logic ack_q;
  logic access;
  logic wr_ctrl;
  logic [7:0] wbyte;
  logic wr_cub;
  logic wr_wde;
  logic [3:0] wr_tsel;
  logic [2:0] win_q;
  logic win_open;
  logic wde_q;
  logic [3:0] tsel_q;
  logic [20:0] cnt_q;
  logic [20:0] limit;
  logic timeout;
  logic refused;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [7:0] ctrl_rd;
  logic [31:0] rd_d;

  // Reset release through two flops
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Fuse is a pin: synchronise, then held in a level register
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      fuse_sync_q <= 2'h0;
      fuse_q <= 1'b0;
    end else begin
      fuse_sync_q <= {fuse_sync_q[0], safety_level_fuse_in};
      fuse_q <= fuse_sync_q[1];
    end
  end
  assign level2 = fuse_q;

  // Oscillator tick from another domain; edge taken after two flops
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      tick_sync_q <= 3'h0;
    end else begin
      tick_sync_q <= {tick_sync_q[1:0], wdt_osc_tick_in};
    end
  end
  assign tick_pulse = tick_sync_q[1] & ~tick_sync_q[2];

  // Single-cycle wait state so every access answers on the second edge
  assign access = (avs_read_in | avs_write_in) & ~ack_q;
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;

  assign wr_ctrl = avs_write_in & ack_q & (avs_address_in == wcg_pkg::CTRL_OFS)
                   & avs_byteenable_in[0];
  assign wbyte = avs_writedata_in[7:0];
  assign wr_cub = wbyte[wcg_pkg::CUB_POS];
  assign wr_wde = wbyte[wcg_pkg::WDE_POS];
  assign wr_tsel = {wbyte[wcg_pkg::TSEL_HI_POS], wbyte[wcg_pkg::TSEL_LO_POS +: 3]};

  // Unlock window counts down four cycles from the opening write
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= 3'h0;
    end else if (wr_ctrl && wr_cub && wr_wde) begin
      win_q <= wcg_pkg::UNLOCK_CYCLES;
    end else if (win_q != 3'h0) begin
      win_q <= win_q - 3'h1;
    end
  end
  assign win_open = (win_q != 3'h0);

  // Enable bit; level two pins it high regardless of writes
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      wde_q <= 1'b0;
    end else if (wr_ctrl && !level2) begin
      if (wr_wde) begin
        wde_q <= 1'b1;
      end else if (win_open && !wr_cub) begin
        wde_q <= 1'b0;
      end
    end
  end

  // Timeout select; free at level one, guarded at level two
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      tsel_q <= wcg_pkg::TSEL_RST;
    end else if (wr_ctrl && !wr_cub) begin
      if (!level2 || win_open) begin
        tsel_q <= wr_tsel;
      end
    end
  end

  // Refused protected write: level-one disable or level-two timeout change with window closed
  assign refused = wr_ctrl & !wr_cub & !win_open &
                   ((!level2 & !wr_wde & wde_q) | (level2 & (wr_tsel != tsel_q)));

  // Timeout limit doubles per code; reserved codes use the longest
  always_comb begin
    limit = 21'h0;
    if (tsel_q > wcg_pkg::TSEL_MAX) begin
      limit = 21'(wcg_pkg::BASE_TIMEOUT) << wcg_pkg::TSEL_MAX;
    end else begin
      limit = 21'(wcg_pkg::BASE_TIMEOUT) << tsel_q;
    end
  end

  // Counter runs only while enabled; level two always runs
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 21'h0;
    end else if (!(wde_q || level2) || wdt_kick_in || timeout) begin
      cnt_q <= 21'h0;
    end else if (tick_pulse) begin
      cnt_q <= cnt_q + 21'h1;
    end
  end
  assign timeout = (wde_q | level2) & tick_pulse & (cnt_q == limit - 21'h1);

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      wdt_reset_out <= 1'b0;
    end else begin
      wdt_reset_out <= timeout;
    end
  end
  assign reset_vector_out = wcg_pkg::RESET_VECTOR;

  // Sticky status; set wins over the read clear
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= (avs_read_in && ack_q && avs_address_in == wcg_pkg::STAT_OFS ? 2'h0 : stat_q)
                | {refused, timeout};
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= 2'h0;
    end else if (avs_write_in && ack_q && avs_address_in == wcg_pkg::MASK_OFS
                 && avs_byteenable_in[0]) begin
      mask_q <= avs_writedata_in[wcg_pkg::EV_COUNT-1:0];
    end
  end
  assign irq_out = |(stat_q & mask_q);

  // Readback
  always_comb begin
    ctrl_rd = 8'h0;
    ctrl_rd[wcg_pkg::TSEL_LO_POS +: 3] = tsel_q[2:0];
    ctrl_rd[wcg_pkg::TSEL_HI_POS] = tsel_q[3];
    ctrl_rd[wcg_pkg::WDE_POS] = wde_q | level2;
    ctrl_rd[wcg_pkg::CUB_POS] = win_open;
    rd_d = 32'h0;
    unique case (avs_address_in)
      wcg_pkg::CTRL_OFS: rd_d = {24'h0, ctrl_rd};
      wcg_pkg::STAT_OFS: rd_d = {30'h0, stat_q};
      wcg_pkg::MASK_OFS: rd_d = {30'h0, mask_q};
      wcg_pkg::VEC_OFS: rd_d = {16'h0, wcg_pkg::RESET_VECTOR};
      default: rd_d = 32'h0;
    endcase
  end
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_out <= 32'h0;
    end else if (avs_read_in && access) begin
      avs_readdata_out <= rd_d;
    end
  end
endmodule
